// file: verilog/urbg_pkg.sv
// urbg_pkg: constants and types of the serial element's register map, baud generator and framing.
// Assumes an 8-bit host bus with a 3-bit register address, all on one core clock.
package urbg_pkg;

   // bus widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int DIV_W  = 16;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_DATA = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_IER  = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_IIR  = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_LCR  = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_MCR  = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_LSR  = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_MSR  = 3'h6;
   localparam logic [ADDR_W-1:0] OFS_SCR  = 3'h7;

   // field positions
   localparam int LCR_DIV_SEL_BIT = 7;
   localparam int LCR_BREAK_BIT   = 6;
   localparam int LSR_DR_BIT      = 0;
   localparam int LSR_OE_BIT      = 1;
   localparam int LSR_FE_BIT      = 3;
   localparam int LSR_THRE_BIT    = 5;
   localparam int LSR_TEMT_BIT    = 6;

   // masks and reset values
   localparam logic [DATA_W-1:0] IER_MASK    = 8'h0f;
   localparam logic [DATA_W-1:0] MCR_MASK    = 8'h1f;
   localparam logic [DATA_W-1:0] IIR_IDLE    = 8'h01;
   localparam logic [DATA_W-1:0] MSR_IDLE    = 8'h00;
   localparam logic [DATA_W-1:0] RST_BYTE    = 8'h00;
   localparam logic [DIV_W-1:0]  RST_DIVISOR = 16'h0000;
   localparam logic [DIV_W-1:0]  DIV_ONE     = 16'h0001;

   // framing: sixteen baud ticks per bit
   localparam logic [3:0] TICK_LAST = 4'hf;
   localparam logic [3:0] TICK_MID  = 4'h7;
   localparam logic [2:0] BIT_LAST  = 3'h7;

   // transmit buffer
   localparam int TX_FIFO_DEPTH = 32;

   typedef struct packed {
      logic              sel;
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } urbg_bus_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } urbg_state_t;

endpackage : urbg_pkg

// file: verilog/urbg_top.sv
// urbg_top: register decode, baud generator, transmit buffer and serial shifters.
// Assumes the host bus pins are driven by logic on CORE_CLK; SERIAL_IN is asynchronous.
//
// Functional notes
// RULE1 - offsets 0-7 decoded; divisor select remaps 0,1
// RULE2 - serial data shifted least significant bit first
// RULE3 - baud divisor from 1 to 65535
// RULE4 - generator output is sixteen times bit rate
// RULE5 - divisor held as low and high bytes
// RULE6 - divisor write reloads baud counter immediately
// RULE7 - host writes both divisor bytes at initialisation
// RULE8 - small divisors limit reference clock frequency
// RULE9 - host keeps data rate at most 56k
// RULE10 - line format bit 7 selects divisor access
// RULE11 - x16 clock driven on its own pin
// RULE12 - divisor reads leave data and enables untouched
`timescale 1ns/10ps

module urbg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             in_ready,
   // drain side
   output      logic             out_valid,
   output      logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign out_valid = (wr_ptr_reg != rd_ptr_reg);
   assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (push)
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
   end
endmodule : urbg_fifo

module urbg_top
   import urbg_pkg::*;
(
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESET,
   // host register port
   input  wire logic              CHIP_SELECT,
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic              READ_STROBE,
   input  wire logic              WRITE_STROBE,
   input  wire logic [DATA_W-1:0] DATA_IN,
   output      logic [DATA_W-1:0] DATA_OUT,
   output      logic              DATA_OE_N,
   output      logic              TX_READY,
   // serial link
   input  wire logic              SERIAL_IN,
   output      logic              SERIAL_OUT,
   output      logic              BIT_CLK_X16_OUT
);

   urbg_bus_t bus;
   assign bus = '{sel: CHIP_SELECT, rd: READ_STROBE, wr: WRITE_STROBE,
                  addr: REG_ADDR, data: DATA_IN};

   // register state
   logic [DATA_W-1:0] ier_reg, lcr_reg, mcr_reg, scr_reg, rbr_reg;
   logic [DATA_W-1:0] div_lo_reg, div_hi_reg;
   logic              dr_reg, oe_reg, fe_reg;
   logic              rd_d_reg, wr_d_reg;
   logic [DATA_W-1:0] data_out_reg;
   logic              oe_n_reg;
   logic              tx_ready_reg;

   // access decode, side effects on the first strobe cycle only
   wire rd_now  = bus.sel && bus.rd;
   wire wr_now  = bus.sel && bus.wr;
   wire rd_take = rd_now && !rd_d_reg;
   wire wr_take = wr_now && !wr_d_reg;
   wire div_sel = lcr_reg[LCR_DIV_SEL_BIT];                         // RULE10

   wire at_data = (bus.addr == OFS_DATA);                            // RULE1
   wire at_ier  = (bus.addr == OFS_IER);
   wire wr_dll  = wr_take && at_data && div_sel;                     // RULE1
   wire wr_thr  = wr_take && at_data && !div_sel;                    // RULE1
   wire wr_dlm  = wr_take && at_ier && div_sel;                      // RULE10
   wire wr_ier  = wr_take && at_ier && !div_sel;                     // RULE10
   wire wr_lcr  = wr_take && (bus.addr == OFS_LCR);
   wire wr_mcr  = wr_take && (bus.addr == OFS_MCR);
   wire wr_scr  = wr_take && (bus.addr == OFS_SCR);
   wire rd_rbr  = rd_take && at_data && !div_sel;                    // RULE12
   wire rd_lsr  = rd_take && (bus.addr == OFS_LSR);

   // divisor value as it stands after this cycle's write
   wire [DATA_W-1:0] div_lo_next = wr_dll ? bus.data : div_lo_reg;
   wire [DATA_W-1:0] div_hi_next = wr_dlm ? bus.data : div_hi_reg;
   wire [DIV_W-1:0]  divisor     = {div_hi_reg, div_lo_reg};         // RULE5
   wire [DIV_W-1:0]  divisor_next = {div_hi_next, div_lo_next};      // RULE5

   // baud generator
   logic [DIV_W-1:0] baud_cnt_reg;
   logic             x16_reg;
   wire              div_live = (divisor != RST_DIVISOR);
   wire              tick     = div_live && (baud_cnt_reg <= DIV_ONE);       // RULE3
   wire [DIV_W-1:0]  half_div = {1'b0, divisor[DIV_W-1:1]};

   always_ff @(posedge CORE_CLK) begin
      if (RESET)
         baud_cnt_reg <= RST_DIVISOR;
      else if (wr_dll || wr_dlm)
         baud_cnt_reg <= divisor_next;                               // RULE6
      else if (tick)
         baud_cnt_reg <= divisor;                                    // RULE3
      else if (div_live)
         baud_cnt_reg <= baud_cnt_reg - DIV_ONE;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET)
         x16_reg <= 1'b0;
      else
         x16_reg <= div_live && (baud_cnt_reg > half_div);           // RULE11
   end

   // transmit buffer
   logic              fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [DATA_W-1:0] fifo_out_data;

   urbg_fifo #(.WIDTH(DATA_W), .DEPTH(TX_FIFO_DEPTH)) tx_fifo (
      .clk       (CORE_CLK),
      .rst       (RESET),
      .in_valid  (wr_thr),
      .in_data   (bus.data),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_out_ready)
   );

   // transmitter
   urbg_state_t       tx_state_reg;
   logic [3:0]        tx_sub_reg;
   logic [2:0]        tx_bit_reg;
   logic [DATA_W-1:0] tx_shift_reg;
   logic              tx_line_reg;
   logic              sout_reg;
   wire               tx_idle    = (tx_state_reg == ST_IDLE);
   wire               tx_bit_end = tick && (tx_sub_reg == TICK_LAST);  // RULE4
   assign fifo_out_ready = tx_idle;

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         tx_state_reg <= ST_IDLE;
         tx_sub_reg   <= '0;
         tx_bit_reg   <= '0;
         tx_shift_reg <= RST_BYTE;
         tx_line_reg  <= 1'b1;
      end else begin
         if (tick)
            tx_sub_reg <= tx_sub_reg + 4'h1;
         case (tx_state_reg)
            ST_IDLE: begin
               if (fifo_out_valid) begin
                  tx_shift_reg <= fifo_out_data;
                  tx_line_reg  <= 1'b0;
                  tx_sub_reg   <= '0;
                  tx_state_reg <= ST_START;
               end
            end
            ST_START: begin
               if (tx_bit_end) begin
                  tx_line_reg  <= tx_shift_reg[0];                   // RULE2
                  tx_bit_reg   <= '0;
                  tx_state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (tx_bit_end) begin
                  if (tx_bit_reg == BIT_LAST) begin
                     tx_line_reg  <= 1'b1;
                     tx_state_reg <= ST_STOP;
                  end else begin
                     tx_shift_reg <= {1'b0, tx_shift_reg[DATA_W-1:1]};  // RULE2
                     tx_line_reg  <= tx_shift_reg[1];                   // RULE2
                     tx_bit_reg   <= tx_bit_reg + 3'h1;
                  end
               end
            end
            ST_STOP: begin
               if (tx_bit_end)
                  tx_state_reg <= ST_IDLE;
            end
            default: tx_state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET)
         sout_reg <= 1'b1;
      else
         sout_reg <= tx_line_reg && !lcr_reg[LCR_BREAK_BIT];
   end

   // receiver
   logic              sin_meta_reg, sin_sync_reg;
   urbg_state_t       rx_state_reg;
   logic [3:0]        rx_sub_reg;
   logic [2:0]        rx_bit_reg;
   logic [DATA_W-1:0] rx_shift_reg;
   logic              rx_done, rx_frame_bad;
   wire               rx_bit_end = tick && (rx_sub_reg == TICK_LAST);  // RULE4
   wire               rx_mid     = tick && (rx_sub_reg == TICK_MID);
   assign rx_done      = (rx_state_reg == ST_STOP) && rx_bit_end;
   assign rx_frame_bad = rx_done && !sin_sync_reg;

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         sin_meta_reg <= 1'b1;
         sin_sync_reg <= 1'b1;
      end else begin
         sin_meta_reg <= SERIAL_IN;
         sin_sync_reg <= sin_meta_reg;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rx_state_reg <= ST_IDLE;
         rx_sub_reg   <= '0;
         rx_bit_reg   <= '0;
         rx_shift_reg <= RST_BYTE;
      end else begin
         if (tick)
            rx_sub_reg <= rx_sub_reg + 4'h1;
         case (rx_state_reg)
            ST_IDLE: begin
               rx_sub_reg <= '0;
               if (!sin_sync_reg)
                  rx_state_reg <= ST_START;
            end
            ST_START: begin
               if (rx_mid) begin
                  rx_sub_reg   <= '0;
                  rx_bit_reg   <= '0;
                  rx_state_reg <= sin_sync_reg ? ST_IDLE : ST_DATA;
               end
            end
            ST_DATA: begin
               if (rx_bit_end) begin
                  rx_shift_reg <= {sin_sync_reg, rx_shift_reg[DATA_W-1:1]};  // RULE2
                  rx_bit_reg   <= rx_bit_reg + 3'h1;
                  if (rx_bit_reg == BIT_LAST)
                     rx_state_reg <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (rx_bit_end)
                  rx_state_reg <= ST_IDLE;
            end
            default: rx_state_reg <= ST_IDLE;
         endcase
      end
   end

   // status flags: a setting event beats a clearing read
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rbr_reg <= RST_BYTE;
         dr_reg  <= 1'b0;
         oe_reg  <= 1'b0;
         fe_reg  <= 1'b0;
      end else begin
         if (rx_done)
            rbr_reg <= rx_shift_reg;
         dr_reg <= rx_done || (dr_reg && !rd_rbr);
         oe_reg <= (rx_done && dr_reg && !rd_rbr) || (oe_reg && !rd_lsr);
         fe_reg <= rx_frame_bad || (fe_reg && !rd_lsr);
      end
   end

   // writable registers
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         ier_reg    <= RST_BYTE;
         lcr_reg    <= RST_BYTE;
         mcr_reg    <= RST_BYTE;
         scr_reg    <= RST_BYTE;
         div_lo_reg <= RST_DIVISOR[DATA_W-1:0];
         div_hi_reg <= RST_DIVISOR[DIV_W-1:DATA_W];
      end else begin
         div_lo_reg <= div_lo_next;                                  // RULE5
         div_hi_reg <= div_hi_next;                                  // RULE5
         if (wr_ier)
            ier_reg <= bus.data & IER_MASK;
         if (wr_lcr)
            lcr_reg <= bus.data;
         if (wr_mcr)
            mcr_reg <= bus.data & MCR_MASK;
         if (wr_scr)
            scr_reg <= bus.data;
      end
   end

   // read selection
   wire thre = !fifo_out_valid;
   wire temt = thre && tx_idle;
   logic [DATA_W-1:0] lsr_val;
   always_comb begin
      lsr_val               = RST_BYTE;
      lsr_val[LSR_DR_BIT]   = dr_reg;
      lsr_val[LSR_OE_BIT]   = oe_reg;
      lsr_val[LSR_FE_BIT]   = fe_reg;
      lsr_val[LSR_THRE_BIT] = thre;
      lsr_val[LSR_TEMT_BIT] = temt;
   end

   wire [DATA_W-1:0] rd_data =
      (at_data && div_sel)         ? div_lo_reg :                    // RULE12
      at_data                      ? rbr_reg :                       // RULE1
      (at_ier && div_sel)          ? div_hi_reg :                    // RULE12
      at_ier                       ? ier_reg :
      (bus.addr == OFS_IIR)        ? IIR_IDLE :
      (bus.addr == OFS_LCR)        ? lcr_reg :
      (bus.addr == OFS_MCR)        ? mcr_reg :
      (bus.addr == OFS_LSR)        ? lsr_val :
      (bus.addr == OFS_MSR)        ? MSR_IDLE : scr_reg;

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rd_d_reg     <= 1'b0;
         wr_d_reg     <= 1'b0;
         data_out_reg <= RST_BYTE;
         oe_n_reg     <= 1'b1;
         tx_ready_reg <= 1'b0;
      end else begin
         rd_d_reg     <= rd_now;
         wr_d_reg     <= wr_now;
         oe_n_reg     <= !rd_now;
         tx_ready_reg <= fifo_in_ready;
         if (rd_now)
            data_out_reg <= rd_data;
      end
   end

   assign DATA_OUT        = data_out_reg;
   assign DATA_OE_N       = oe_n_reg;
   assign TX_READY        = tx_ready_reg;
   assign SERIAL_OUT      = sout_reg;
   assign BIT_CLK_X16_OUT = x16_reg;

endmodule : urbg_top

// file: verification/urbg_top_chk.sv
// urbg_top_chk: port-level assertions on register port and x16 clock.
// Assumes host strobes synchronous to CORE_CLK; bound onto urbg_top.
`timescale 1ns/10ps
module urbg_chk
   import urbg_pkg::*;
(
   // clock and reset
   input wire logic              CORE_CLK,
   input wire logic              RESET,
   // host port
   input wire logic              CHIP_SELECT,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic              READ_STROBE,
   input wire logic              WRITE_STROBE,
   input wire logic [DATA_W-1:0] DATA_IN,
   input wire logic [DATA_W-1:0] DATA_OUT,
   input wire logic              DATA_OE_N,
   // baud output
   input wire logic              BIT_CLK_X16_OUT
);
   logic              rd_reg, wr_reg, bclk_reg, per_ok_reg, pend_reg;
   logic [DATA_W-1:0] lcr_reg, scr_reg;
   logic [DIV_W-1:0]  div_reg;
   logic [16:0]       per_reg, since_reg;
   wire rd_take = CHIP_SELECT && READ_STROBE && !rd_reg;
   wire wr_take = CHIP_SELECT && WRITE_STROBE && !wr_reg;
   wire divisor_access_select    = lcr_reg[LCR_DIV_SEL_BIT];
   wire lo_wr   = wr_take && divisor_access_select && REG_ADDR == OFS_DATA;
   wire hi_wr   = wr_take && divisor_access_select && REG_ADDR == OFS_IER;
   wire div_wr  = lo_wr || hi_wr;
   wire rise    = BIT_CLK_X16_OUT && !bclk_reg;
   // shadow of host-visible state, rebuilt from bus traffic
   always_ff @(posedge CORE_CLK) begin
      rd_reg     <= CHIP_SELECT && READ_STROBE;
      wr_reg     <= CHIP_SELECT && WRITE_STROBE;
      bclk_reg   <= BIT_CLK_X16_OUT;
      per_reg    <= rise ? 17'h1 : per_reg + 17'h1;
      since_reg  <= (RESET || div_wr) ? 17'h0 : since_reg + 17'h1;
      per_ok_reg <= !RESET && !div_wr && (per_ok_reg || rise);
      pend_reg   <= !RESET && (div_wr || (pend_reg && !rise));
      if (RESET) begin
         lcr_reg <= 8'h00;
         scr_reg <= 8'h00;
         div_reg <= 16'h0000;
      end else begin
         if (wr_take && REG_ADDR == OFS_LCR) lcr_reg <= DATA_IN;
         if (wr_take && REG_ADDR == OFS_SCR) scr_reg <= DATA_IN;
         if (lo_wr) div_reg[7:0] <= DATA_IN;
         if (hi_wr) div_reg[15:8] <= DATA_IN;
      end
   end
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);
   AST_OE_LOW: assert property (rd_take |=> !DATA_OE_N)
      else $error("read not answered with bus enable");
   AST_OE_HIGH: assert property (!(CHIP_SELECT && READ_STROBE) |=> DATA_OE_N)
      else $error("bus enable left on after read");
   AST_SCR_RD: assert property (rd_take && REG_ADDR == OFS_SCR |=> DATA_OUT == scr_reg)
      else $error("scratch read mismatch");
   AST_LCR_RD: assert property (rd_take && REG_ADDR == OFS_LCR |=> DATA_OUT == lcr_reg)
      else $error("line format read mismatch");
   AST_DLO_RD: assert property (rd_take && divisor_access_select && REG_ADDR == OFS_DATA |=>
      DATA_OUT == div_reg[7:0])
      else $error("divisor low read mismatch");
   AST_DHI_RD: assert property (rd_take && divisor_access_select && REG_ADDR == OFS_IER |=>
      DATA_OUT == div_reg[15:8])
      else $error("divisor high read mismatch");
   AST_PERIOD: assert property (rise && per_ok_reg |-> per_reg == {1'b0, div_reg})
      else $error("x16 clock period differs from divisor");
   AST_STOPPED: assert property (since_reg > 17'h2 && div_reg == 16'h0 |->
      !BIT_CLK_X16_OUT)
      else $error("x16 clock runs with zero divisor");
   AST_RELOAD: assert property (pend_reg && div_reg != 16'h0 |->
      since_reg <= {1'b0, div_reg} + 17'h2)
      else $error("divisor write did not restart counter");
endmodule : urbg_chk

bind urbg_top urbg_chk urbg_chk_inst (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .CHIP_SELECT(CHIP_SELECT),
   .REG_ADDR(REG_ADDR), .READ_STROBE(READ_STROBE), .WRITE_STROBE(WRITE_STROBE),
   .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
   .BIT_CLK_X16_OUT(BIT_CLK_X16_OUT));

// file: verification/urbg_serial_peer.sv
// urbg_serial_peer: far-end serial sender, 8 data bits, one stop bit.
// Assumes bit_cycles is sixteen times the divisor programmed by the bench.
`timescale 1ns/10ps
module urbg_serial_peer (
   // control
   input wire logic        clk,
   input wire logic        go,
   input wire logic [7:0]  tx_byte,
   input wire logic [15:0] bit_cycles,
   // line, marking when idle
   output     logic        line
);
   initial line = 1'b1;
   always @(posedge clk) begin : send
      logic [9:0] frame;
      int         i;
      frame = {1'b1, tx_byte, 1'b0};
      if (go) begin
         for (i = 0; i < 10; i++) begin
            line <= frame[i];
            repeat (bit_cycles) @(posedge clk);
         end
      end
   end
endmodule : urbg_serial_peer

// file: verification/urbg_top_test.sv
// urbg_top_test: register, buffer, baud and serial scenarios via host port.
// Assumes urbg_top from verilog/ and the serial peer model.
`timescale 1ns/10ps
module urbg_top_test
   import urbg_pkg::*;
;
   localparam int BITC = 16 * 140;
   logic       clk, rst, cs, rd_s, wr_s, go;
   logic [2:0] addr;
   logic [7:0] din, dout, pbyte;
   logic       oe_n, tx_rdy, sin, sout, bclk;
   int         n_mismatch, check_count, cyc, i;

   urbg_top urbg_top_inst (
      .CORE_CLK(clk), .RESET(rst), .CHIP_SELECT(cs), .REG_ADDR(addr),
      .READ_STROBE(rd_s), .WRITE_STROBE(wr_s), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE_N(oe_n), .TX_READY(tx_rdy), .SERIAL_IN(sin), .SERIAL_OUT(sout),
      .BIT_CLK_X16_OUT(bclk));
   urbg_serial_peer urbg_serial_peer_inst (
      .clk(clk), .go(go), .tx_byte(pbyte), .bit_cycles(16'h08c0), .line(sin));

   always #4 clk = ~clk;

   task automatic give_verdict();
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check8

   task automatic checkn(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : checkn

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      cs <= 1'b1;
      wr_s <= 1'b1;
      addr <= a;
      din <= d;
      @(posedge clk);
      cs <= 1'b0;
      wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      cs <= 1'b1;
      rd_s <= 1'b1;
      addr <= a;
      repeat (2) @(posedge clk);
      #1 check8(dout, e);
      @(posedge clk);
      cs <= 1'b0;
      rd_s <= 1'b0;
   endtask : rd

   task automatic period(input logic [15:0] dv);
      int t0;
      wr(OFS_DATA, dv[7:0]);
      wr(OFS_IER, dv[15:8]);
      @(posedge bclk);
      t0 = cyc;
      @(posedge bclk);
      checkn(cyc - t0, int'(dv));
   endtask : period

   task automatic tx_chk(input logic [7:0] d);
      logic [7:0] got;
      int         k;
      wr(OFS_DATA, d);
      @(negedge sout);
      repeat (BITC + BITC / 2) @(posedge clk);
      for (k = 0; k < 8; k++) begin
         got[k] = sout;
         repeat (BITC) @(posedge clk);
      end
      check8(got, d);
   endtask : tx_chk

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {cs, rd_s, wr_s, go, addr, din, pbyte} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_LSR, 8'h60);
      rd(OFS_IIR, IIR_IDLE);
      rd(OFS_MSR, MSR_IDLE);
      wr(OFS_SCR, 8'ha5);
      rd(OFS_SCR, 8'ha5);
      wr(OFS_IER, 8'hff);
      rd(OFS_IER, IER_MASK);
      // generator stopped: fill the buffer until refused
      for (i = 0; i < 34; i++) wr(OFS_DATA, i[7:0]);
      @(posedge clk);
      #1 check8({7'h0, tx_rdy}, 8'h00);
      rd(OFS_LSR, 8'h00);
      wr(OFS_LCR, 8'h83);
      rd(OFS_LCR, 8'h83);
      wr(OFS_DATA, 8'h04);
      wr(OFS_IER, 8'h00);
      rd(OFS_DATA, 8'h04);
      rd(OFS_IER, 8'h00);
      wr(OFS_LCR, 8'h03);
      rd(OFS_IER, IER_MASK);
      repeat (25000) @(posedge clk);
      rd(OFS_LSR, 8'h60);
      #1 check8({7'h0, tx_rdy}, 8'h01);
      wr(OFS_LCR, 8'h83);
      period(16'h0004);
      period(16'h0005);
      period(16'h0104);
      period(16'h008c);
      rd(OFS_IER, 8'h00);
      wr(OFS_LCR, 8'h03);
      tx_chk(8'h4b);
      pbyte <= 8'ha6;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (11 * BITC) @(posedge clk);
      rd(OFS_LSR, 8'h61);
      rd(OFS_DATA, 8'ha6);
      rd(OFS_LSR, 8'h60);
      give_verdict();
   end
endmodule : urbg_top_test
